// File: pkg/strap_loader_pkg.sv
// Summary of operation
// - the port 1 flow override select default is loaded from its strap, low by default.
// - with that strap low, flow control follows negotiation and advertisement bit 10 is set.
// - with that strap high, flow control follows the tx/rx pause enables and bit 10 is clear.
// - with the crossover override bit clear, port 2 auto crossover follows its strap.
// - with the crossover override bit set, the port 2 auto crossover strap is ignored.
// - with auto crossover strap low and override clear, manual strap 0 is straight, 1 crossed.
// - the port 2 negotiation enable default follows its strap, high by default.
// - the negotiation strap also sets speed low bit, duplex, 10M adverts and the mode field.
// - pause enables apply only under manual full duplex; clear turns pause off, set on.
package strap_loader_pkg;

  // strap pull defaults, also the values shown while reset is held
  localparam logic P1_FLOW_STRAP_DFLT = 1'b0;
  localparam logic P2_AUTO_XOVER_STRAP_DFLT = 1'b1;
  localparam logic P2_MANUAL_XOVER_STRAP_DFLT = 1'b0;
  localparam logic P2_NEG_STRAP_DFLT = 1'b1;
  localparam logic P2_SPEED_STRAP_DFLT = 1'b1;
  localparam logic P2_DUPLEX_STRAP_DFLT = 1'b1;

  // pinout encoding
  localparam logic XOVER_STRAIGHT = 1'b0;
  localparam logic XOVER_CROSSED = 1'b1;

  // advertisement register field positions
  localparam int ADV_W = 16;
  localparam int ADV_PAUSE_BIT = 10;
  localparam int ADV_10FD_BIT = 6;
  localparam int ADV_10HD_BIT = 5;
  localparam logic [ADV_W-1:0] ADV_BASE = 16'h0181;

  // phy mode field
  localparam int MODE_W = 3;
  localparam logic [MODE_W-1:0] MODE_ALL_CAPABLE = 3'h7;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_HOLD = 2'b10
  } load_state_t;

endpackage : strap_loader_pkg

// File: rtl/strap_default_decode.sv
`timescale 1ns/1ps
`default_nettype none
module strap_default_decode
  import strap_loader_pkg::*;
(
  // strap values
  input wire logic p1_flow_override_strap_i,
  input wire logic p2_negotiation_strap_i,
  input wire logic p2_speed_strap_i,
  input wire logic p2_duplex_strap_i,
  // derived defaults
  output logic [ADV_W-1:0] p1_adv_o,
  output logic [ADV_W-1:0] p2_adv_o,
  output logic p2_speed_low_o,
  output logic p2_duplex_o,
  output logic [MODE_W-1:0] p2_mode_o
);

  always_comb begin
    p1_adv_o = ADV_BASE;
    p1_adv_o[ADV_PAUSE_BIT] = ~p1_flow_override_strap_i;
  end

  // with negotiation on, both 10M abilities are offered on top of the base set, pause excluded; otherwise the
  // fixed speed and duplex straps decide what is offered
  always_comb begin
    p2_adv_o = ADV_BASE;
    p2_speed_low_o = 1'b1;
    p2_duplex_o = 1'b1;
    p2_mode_o = MODE_ALL_CAPABLE;
    p2_adv_o[ADV_10FD_BIT] = 1'b1;
    p2_adv_o[ADV_10HD_BIT] = 1'b1;
    if (!p2_negotiation_strap_i) begin
      p2_speed_low_o = p2_speed_strap_i;
      p2_duplex_o = p2_duplex_strap_i;
      p2_mode_o = {1'b0, p2_speed_strap_i, p2_duplex_strap_i};
      p2_adv_o[ADV_10FD_BIT] = ~p2_speed_strap_i & p2_duplex_strap_i;
      p2_adv_o[ADV_10HD_BIT] = ~p2_speed_strap_i;
    end
  end

endmodule : strap_default_decode
`default_nettype wire

// File: rtl/port_strap_default_loader.sv
`timescale 1ns/1ps
`default_nettype none
module port_strap_default_loader
  import strap_loader_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // strap inputs
  input wire logic p1_flow_override_strap_i,
  input wire logic p2_auto_crossover_strap_i,
  input wire logic p2_manual_crossover_strap_i,
  input wire logic p2_negotiation_strap_i,
  input wire logic p2_speed_strap_i,
  input wire logic p2_duplex_strap_i,
  // live control from software and the phy
  input wire logic crossover_override_bit_i,
  input wire logic sw_auto_crossover_i,
  input wire logic sw_crossover_select_i,
  input wire logic p1_tx_pause_enable_i,
  input wire logic p1_rx_pause_enable_i,
  input wire logic p1_full_duplex_i,
  input wire logic p1_neg_enabled_i,
  input wire logic p1_neg_tx_pause_i,
  input wire logic p1_neg_rx_pause_i,
  // held defaults
  output logic defaults_valid_o,
  output logic p1_flow_override_select_o,
  output logic [ADV_W-1:0] p1_adv_default_o,
  output logic [ADV_W-1:0] p2_adv_default_o,
  output logic p2_negotiation_enable_o,
  output logic p2_speed_select_low_o,
  output logic p2_duplex_select_o,
  output logic [MODE_W-1:0] p2_phy_mode_o,
  // port 2 crossover
  output logic p2_auto_crossover_en_o,
  output logic p2_crossover_select_o,
  // port 1 pause frame control
  output logic p1_pause_gen_en_o,
  output logic p1_pause_detect_en_o
);

  load_state_t state;
  logic cap_auto_xover;
  logic cap_manual_xover;
  logic [ADV_W-1:0] next_p1_adv;
  logic [ADV_W-1:0] next_p2_adv;
  logic next_speed_low;
  logic next_duplex;
  logic [MODE_W-1:0] next_mode;
  logic load_now;

  assign load_now = (state == ST_LOAD);

  strap_default_decode u_decode (
    .p1_flow_override_strap_i(p1_flow_override_strap_i),
    .p2_negotiation_strap_i(p2_negotiation_strap_i),
    .p2_speed_strap_i(p2_speed_strap_i),
    .p2_duplex_strap_i(p2_duplex_strap_i),
    .p1_adv_o(next_p1_adv),
    .p2_adv_o(next_p2_adv),
    .p2_speed_low_o(next_speed_low),
    .p2_duplex_o(next_duplex),
    .p2_mode_o(next_mode)
  );

  // one capture at the first edge after release, then locked; straps
  // may be reused as outputs afterwards, so later changes must not leak
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ST_LOAD;
    end else begin
      unique case (state)
        ST_LOAD: begin
          state <= ST_HOLD;
        end
        ST_HOLD: begin
          state <= ST_HOLD;
        end
        default: begin
          state <= ST_LOAD;
        end
      endcase
    end
  end

  assign defaults_valid_o = (state == ST_HOLD);

  // reset shows the defaults that the pull values would give
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      p1_flow_override_select_o <= P1_FLOW_STRAP_DFLT;
      p1_adv_default_o <= ADV_BASE | (16'h0001 << ADV_PAUSE_BIT);
      p2_adv_default_o <= ADV_BASE | (16'h0001 << ADV_10FD_BIT)
                          | (16'h0001 << ADV_10HD_BIT);
      p2_negotiation_enable_o <= P2_NEG_STRAP_DFLT;
      p2_speed_select_low_o <= P2_SPEED_STRAP_DFLT;
      p2_duplex_select_o <= P2_DUPLEX_STRAP_DFLT;
      p2_phy_mode_o <= MODE_ALL_CAPABLE;
      cap_auto_xover <= P2_AUTO_XOVER_STRAP_DFLT;
      cap_manual_xover <= P2_MANUAL_XOVER_STRAP_DFLT;
    end else if (load_now) begin
      p1_flow_override_select_o <= p1_flow_override_strap_i;
      p1_adv_default_o <= next_p1_adv;
      p2_adv_default_o <= next_p2_adv;
      p2_negotiation_enable_o <= p2_negotiation_strap_i;
      p2_speed_select_low_o <= next_speed_low;
      p2_duplex_select_o <= next_duplex;
      p2_phy_mode_o <= next_mode;
      cap_auto_xover <= p2_auto_crossover_strap_i;
      cap_manual_xover <= p2_manual_crossover_strap_i;
    end
  end

  // crossover follows the override bit live, one cycle behind
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      p2_auto_crossover_en_o <= P2_AUTO_XOVER_STRAP_DFLT;
      p2_crossover_select_o <= XOVER_STRAIGHT;
    end else if (crossover_override_bit_i) begin
      p2_auto_crossover_en_o <= sw_auto_crossover_i;
      p2_crossover_select_o <= sw_crossover_select_i;
    end else begin
      p2_auto_crossover_en_o <= cap_auto_xover;
      // the manual pinout only matters while auto crossover is off
      p2_crossover_select_o <= cap_auto_xover ? XOVER_STRAIGHT
                               : (cap_manual_xover ? XOVER_CROSSED
                                  : XOVER_STRAIGHT);
    end
  end

  // pause frames exist only in full duplex; half duplex uses
  // backpressure, handled elsewhere
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      p1_pause_gen_en_o <= 1'b0;
      p1_pause_detect_en_o <= 1'b0;
    end else if (!p1_full_duplex_i) begin
      p1_pause_gen_en_o <= 1'b0;
      p1_pause_detect_en_o <= 1'b0;
    end else if (p1_flow_override_select_o) begin
      p1_pause_gen_en_o <= p1_tx_pause_enable_i;
      p1_pause_detect_en_o <= p1_rx_pause_enable_i;
    end else begin
      p1_pause_gen_en_o <= p1_neg_enabled_i & p1_neg_tx_pause_i;
      p1_pause_detect_en_o <= p1_neg_enabled_i & p1_neg_rx_pause_i;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  AST_P1_SELECT_LOAD: assert property (
    load_now |=> p1_flow_override_select_o == $past(p1_flow_override_strap_i))
    else $error("flow override select not loaded from strap");

  AST_ADV_PAUSE_SET: assert property (
    (defaults_valid_o && !p1_flow_override_select_o)
    |-> p1_adv_default_o[ADV_PAUSE_BIT])
    else $error("symmetric pause not advertised");

  AST_ADV_PAUSE_CLR: assert property (
    (defaults_valid_o && p1_flow_override_select_o)
    |-> !p1_adv_default_o[ADV_PAUSE_BIT])
    else $error("symmetric pause advertised under manual control");

  AST_MANUAL_PAUSE: assert property (
    (p1_flow_override_select_o && p1_full_duplex_i)
    |=> p1_pause_gen_en_o == $past(p1_tx_pause_enable_i)
        && p1_pause_detect_en_o == $past(p1_rx_pause_enable_i))
    else $error("manual pause enables not followed");

  AST_AUTO_XOVER: assert property (
    (defaults_valid_o && !crossover_override_bit_i)
    |=> p2_auto_crossover_en_o == $past(cap_auto_xover))
    else $error("auto crossover does not follow strap");

  AST_XOVER_OVERRIDE: assert property (
    crossover_override_bit_i
    |=> p2_auto_crossover_en_o == $past(sw_auto_crossover_i)
        && p2_crossover_select_o == $past(sw_crossover_select_i))
    else $error("crossover strap not ignored under override");

  AST_MANUAL_XOVER: assert property (
    (defaults_valid_o && !crossover_override_bit_i && !cap_auto_xover)
    |=> p2_crossover_select_o == $past(cap_manual_xover))
    else $error("manual pinout wrong");

  AST_NEG_LOAD: assert property (
    load_now |=> p2_negotiation_enable_o == $past(p2_negotiation_strap_i))
    else $error("negotiation enable not loaded from strap");

  AST_NEG_KNOCK_ON: assert property (
    (defaults_valid_o && p2_negotiation_enable_o)
    |-> p2_phy_mode_o == MODE_ALL_CAPABLE && p2_speed_select_low_o
        && p2_duplex_select_o && p2_adv_default_o[ADV_10FD_BIT]
        && p2_adv_default_o[ADV_10HD_BIT])
    else $error("negotiation knock-on defaults wrong");

  AST_NEG_OFF_FIXED: assert property (
    (defaults_valid_o && !p2_negotiation_enable_o)
    |-> p2_phy_mode_o == {1'b0, p2_speed_select_low_o, p2_duplex_select_o}
        && p2_adv_default_o[ADV_10HD_BIT] == !p2_speed_select_low_o
        && !p2_adv_default_o[ADV_PAUSE_BIT])
    else $error("fixed speed and duplex defaults disagree");

  // gated by valid: the select only settles at the capture edge
  AST_NEG_PAUSE: assert property (
    (defaults_valid_o && !p1_flow_override_select_o && p1_full_duplex_i)
    |=> p1_pause_gen_en_o
        == ($past(p1_neg_enabled_i) && $past(p1_neg_tx_pause_i))
        && p1_pause_detect_en_o
        == ($past(p1_neg_enabled_i) && $past(p1_neg_rx_pause_i)))
    else $error("negotiated pause results not followed");

  AST_HALF_NO_PAUSE: assert property (
    !p1_full_duplex_i |=> !p1_pause_gen_en_o && !p1_pause_detect_en_o)
    else $error("pause active outside full duplex");

  AST_HOLD_STABLE: assert property (
    defaults_valid_o |=> defaults_valid_o
      && $stable(p1_flow_override_select_o) && $stable(p2_phy_mode_o)
      && $stable(p2_negotiation_enable_o) && $stable(cap_auto_xover))
    else $error("held defaults changed");

endmodule : port_strap_default_loader
`default_nettype wire

// File: testbench/strap_source.sv
`timescale 1ns/1ps
`default_nettype none
module strap_source (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // wanted strap levels
  input wire logic [5:0] level_i,
  // strap pins
  output logic [5:0] strap_o
);
  logic taken;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      taken <= 1'b0;
    end else begin
      taken <= 1'b1;
    end
  end

  // pins stop holding after the capture edge; inverted so a late read
  // can never match by luck
  assign strap_o = taken ? ~level_i : level_i;
endmodule : strap_source
`default_nettype wire

// File: testbench/port_strap_default_loader_tb.sv
`timescale 1ns/1ps
`default_nettype none
module port_strap_default_loader_tb;
  import strap_loader_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [5:0] level = 6'h00;
  logic [5:0] strap;
  logic ovr = 1'b0, sw_auto = 1'b0, sw_sel = 1'b0;
  logic [5:0] live = 6'h00;
  logic valid, sel, neg, spd, dup, auto_en, xsel, gen, det;
  logic [15:0] adv1, adv2;
  logic [2:0] mode;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  strap_source src (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .level_i(level), .strap_o(strap));

  port_strap_default_loader dut (.ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i), .p1_flow_override_strap_i(strap[5]),
    .p2_auto_crossover_strap_i(strap[4]),
    .p2_manual_crossover_strap_i(strap[3]),
    .p2_negotiation_strap_i(strap[2]), .p2_speed_strap_i(strap[1]),
    .p2_duplex_strap_i(strap[0]), .crossover_override_bit_i(ovr),
    .sw_auto_crossover_i(sw_auto), .sw_crossover_select_i(sw_sel),
    .p1_full_duplex_i(live[5]), .p1_neg_enabled_i(live[4]),
    .p1_tx_pause_enable_i(live[3]), .p1_rx_pause_enable_i(live[2]),
    .p1_neg_tx_pause_i(live[1]), .p1_neg_rx_pause_i(live[0]),
    .defaults_valid_o(valid), .p1_flow_override_select_o(sel),
    .p1_adv_default_o(adv1), .p2_adv_default_o(adv2),
    .p2_negotiation_enable_o(neg), .p2_speed_select_low_o(spd),
    .p2_duplex_select_o(dup), .p2_phy_mode_o(mode),
    .p2_auto_crossover_en_o(auto_en), .p2_crossover_select_o(xsel),
    .p1_pause_gen_en_o(gen), .p1_pause_detect_en_o(det));

  task automatic step();
    @(posedge ref_clk_i);
    #1;
  endtask : step

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic check_held(input logic [5:0] s);
    logic [15:0] a2;
    a2 = ADV_BASE;
    a2[ADV_10FD_BIT] = s[2] | (~s[1] & s[0]);
    a2[ADV_10HD_BIT] = s[2] | ~s[1];
    check(valid, 1'b1);
    check(sel, s[5]);
    check(adv1, s[5] ? 16'h0181 : 16'h0581);
    check(neg, s[2]);
    check(spd, s[2] | s[1]);
    check(dup, s[2] | s[0]);
    check(mode, s[2] ? 3'h7 : {1'b0, s[1], s[0]});
    check(adv2, a2);
  endtask : check_held

  task automatic summarize();
    $display("Checks: %0d, errors: %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // a full sweep needs about 4930 cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    logic [5:0] s;
    logic e_gen, e_det;
    for (int i = 0; i < 64; i++) begin
      s = i[5:0];
      sys_rst_i = 1'b1;
      level = s;
      repeat (10) step();
      check(valid, 1'b0);
      check(adv1, 16'h0581);
      check(adv2, 16'h01E1);
      check({neg, mode}, 4'hF);
      check({sel, spd, dup, auto_en, xsel, gen, det}, 7'h38);
      sys_rst_i = 1'b0;
      step();
      check_held(s);
      ovr = 1'b1;
      sw_auto = ~s[4];
      sw_sel = ~s[3];
      step();
      check({auto_en, xsel}, {~s[4], ~s[3]});
      ovr = 1'b0;
      step();
      check(auto_en, s[4]);
      check(xsel, s[4] ? XOVER_STRAIGHT : s[3]);
      for (int j = 0; j < 64; j++) begin
        live = j[5:0];
        step();
        e_gen = live[5] & (s[5] ? live[3] : live[4] & live[1]);
        e_det = live[5] & (s[5] ? live[2] : live[4] & live[0]);
        check({gen, det}, {e_gen, e_det});
      end
      // straps now show inverted levels; held defaults must not move
      check_held(s);
    end
    summarize();
  end
endmodule : port_strap_default_loader_tb
`default_nettype wire
